// file: hw/hsdc_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hsdc_top
  import hsdc_pkg::*;
#(
  parameter int MASK_CYCLES = HSDC_MASK_CYCLES
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [1:0]         src_sel_alt,
  input  wire logic [1:0]         alt_drive,
  input  wire logic [1:0]         overcurrent_det,
  input  wire logic               stop_mode,
  input  wire logic               special_mode,
  output hsdc_pkg::hsdc_drive_t   drive_out,
  output logic                    driver_module_irq
);
  import hsdc_pkg::*;

  localparam int CW = $clog2(MASK_CYCLES + 1);

  // ==========================================================
  // Register state
  logic [1:0]  driver_data_bit_ff;
  logic [1:0]  driver_enable_ff;
  logic [1:0]  overcurrent_mask_en_ff;
  logic        overcurrent_irq_en_ff;
  logic [1:0]  overcurrent_flag_ff;
  logic [7:0]  factory_test_ff;
  logic [1:0]  oc_sync1_ff;
  logic [1:0]  oc_sync2_ff;
  logic        stop_d_ff;
  logic [1:0]  cmd_d_ff;
  logic [CW-1:0] mask_cnt_ff [HSDC_NDRV];
  logic [1:0]  in_window;
  logic [1:0]  drv_cmd;
  logic [1:0]  oc_event;

  // ==========================================================
  // AXI4-Lite write channel
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        wr_do;
  logic        wr_hit;

  // Address and data held until the response; either may come first
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign wr_do = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit = (awaddr_ff == HSDC_ADDR_DATA) || (awaddr_ff == HSDC_ADDR_CFG) ||
                  (awaddr_ff == HSDC_ADDR_TEST) || (awaddr_ff == HSDC_ADDR_IEN) ||
                  (awaddr_ff == HSDC_ADDR_FLG);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= HSDC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? HSDC_RESP_OKAY : HSDC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_do && wstrb_ff[0];

  // ==========================================================
  // Control registers
  logic stop_entry;
  assign stop_entry = stop_mode && !stop_d_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_d_ff <= 1'b0;
    end else begin
      stop_d_ff <= stop_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_data_bit_ff <= HSDC_RST_DRV;
    end else if (stop_entry) begin
      driver_data_bit_ff <= 2'b00;
    end else if (wr_lane0 && awaddr_ff == HSDC_ADDR_DATA) begin
      driver_data_bit_ff <= wdata_ff[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_enable_ff       <= HSDC_RST_DRV;
      overcurrent_mask_en_ff <= HSDC_RST_DRV;
    end else if (wr_lane0 && awaddr_ff == HSDC_ADDR_CFG) begin
      driver_enable_ff <= wdata_ff[HSDC_POS_EN +: 2];
      // Lock uses the old enable, so one write may set enable and mask together
      for (int i = 0; i < HSDC_NDRV; i++) begin
        if (!driver_enable_ff[i]) begin
          overcurrent_mask_en_ff[i] <= wdata_ff[HSDC_POS_MASK + i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_irq_en_ff <= 1'b0;
    end else if (wr_lane0 && awaddr_ff == HSDC_ADDR_IEN) begin
      overcurrent_irq_en_ff <= wdata_ff[HSDC_POS_IEN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      factory_test_ff <= HSDC_RST_TEST;
    end else if (wr_lane0 && awaddr_ff == HSDC_ADDR_TEST && special_mode) begin
      factory_test_ff <= wdata_ff[7:0];
    end
  end

  // ==========================================================
  // Over-current path, one instance per driver
  // Detect pins are asynchronous; only the second flop feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_sync1_ff <= 2'b00;
      oc_sync2_ff <= 2'b00;
      cmd_d_ff    <= 2'b00;
    end else begin
      oc_sync1_ff <= overcurrent_det;
      oc_sync2_ff <= oc_sync1_ff;
      cmd_d_ff    <= drv_cmd;
    end
  end

  for (genvar g = 0; g < HSDC_NDRV; g++) begin : g_drv
    // Source select: routed timer/PWM or data bit
    assign drv_cmd[g] = src_sel_alt[g] ? alt_drive[g] : driver_data_bit_ff[g];
    assign in_window[g] = overcurrent_mask_en_ff[g] && (mask_cnt_ff[g] != '0);
    assign oc_event[g] = oc_sync2_ff[g] && !in_window[g];

    // Window restarts on each off-to-on edge of the command while the driver is enabled
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mask_cnt_ff[g] <= '0;
      end else if (drv_cmd[g] && !cmd_d_ff[g] && driver_enable_ff[g]) begin
        mask_cnt_ff[g] <= CW'(MASK_CYCLES);
      end else if (mask_cnt_ff[g] != '0) begin
        mask_cnt_ff[g] <= mask_cnt_ff[g] - 1'b1;
      end
    end

    // Set wins over a same-cycle clear; stop mode never touches it
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        overcurrent_flag_ff[g] <= 1'b0;
      end else if (oc_event[g]) begin
        overcurrent_flag_ff[g] <= 1'b1;
      end else if (wr_lane0 && awaddr_ff == HSDC_ADDR_FLG && wdata_ff[g]) begin
        overcurrent_flag_ff[g] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs to the analog stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_out <= '0;
    end else begin
      drive_out.drv_en <= driver_enable_ff;
      drive_out.drv_on <= drv_cmd & driver_enable_ff & ~overcurrent_flag_ff;
    end
  end

  // Registered so the request cannot glitch across stop transitions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_module_irq <= 1'b0;
    end else begin
      driver_module_irq <= overcurrent_irq_en_ff && (|overcurrent_flag_ff)
                           && !stop_mode;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [1:0]  data_view;

  assign data_view = (driver_enable_ff & drv_cmd) |
                     (~driver_enable_ff & driver_data_bit_ff);
  // Read data captured at the address handshake: a live source is a snapshot
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      HSDC_ADDR_DATA: rd_mux[1:0] = data_view;
      HSDC_ADDR_CFG: begin
        rd_mux[HSDC_POS_EN +: 2]   = driver_enable_ff;
        rd_mux[HSDC_POS_MASK +: 2] = overcurrent_mask_en_ff;
      end
      HSDC_ADDR_TEST: rd_mux[7:0] = factory_test_ff;
      HSDC_ADDR_IEN: rd_mux[HSDC_POS_IEN] = overcurrent_irq_en_ff;
      HSDC_ADDR_FLG: rd_mux[1:0] = overcurrent_flag_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= HSDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? HSDC_RESP_OKAY : HSDC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    overcurrent_flag_ff[0] && !(wr_lane0 && awaddr_ff == HSDC_ADDR_FLG && wdata_ff[0])
    |=> overcurrent_flag_ff[0]) else $error("flag dropped without clear");
  a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    oc_sync2_ff[1] && !in_window[1] |=> overcurrent_flag_ff[1])
    else $error("flag not set on over-current");
  a_shutdown_off: assert property (@(posedge aclk) disable iff (!aresetn)
    overcurrent_flag_ff[0] |=> !drive_out.drv_on[0]) else $error("driver on with flag");
  a_return_src: assert property (@(posedge aclk) disable iff (!aresetn)
    !overcurrent_flag_ff[1] && driver_enable_ff[1]
    |=> drive_out.drv_on[1] == $past(drv_cmd[1])) else $error("source not restored");
  a_clear_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lane0 && awaddr_ff == HSDC_ADDR_FLG && !wdata_ff[0] && overcurrent_flag_ff[0]
    |=> overcurrent_flag_ff[0]) else $error("write zero cleared flag");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !overcurrent_irq_en_ff |=> !driver_module_irq) else $error("irq while disabled");
  a_irq_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_mode |=> !driver_module_irq) else $error("irq in stop mode");
  a_mask_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    driver_enable_ff[0] |=> $stable(overcurrent_mask_en_ff[0]))
    else $error("mask bit changed while enabled");
  a_mask_window: assert property (@(posedge aclk) disable iff (!aresetn)
    in_window[0] && !overcurrent_flag_ff[0] |=> !overcurrent_flag_ff[0])
    else $error("flag set inside mask window");
  a_test_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    !special_mode |=> $stable(factory_test_ff)) else $error("test reg written");
  a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_mode && !stop_d_ff |=> driver_data_bit_ff == 2'b00) else $error("data kept in stop");
  a_flag_hold_one: assert property (@(posedge aclk) disable iff (!aresetn)
    overcurrent_flag_ff[1] && !(wr_lane0 && awaddr_ff == HSDC_ADDR_FLG && wdata_ff[1])
    |=> overcurrent_flag_ff[1]) else $error("flag one dropped without clear");
  a_shutdown_one: assert property (@(posedge aclk) disable iff (!aresetn)
    overcurrent_flag_ff[1] |=> !drive_out.drv_on[1]) else $error("driver one on with flag");
  a_irq_merge: assert property (@(posedge aclk) disable iff (!aresetn)
    overcurrent_irq_en_ff && overcurrent_flag_ff[1] && !stop_mode |=> driver_module_irq)
    else $error("flag one not on shared irq");
  a_window_one: assert property (@(posedge aclk) disable iff (!aresetn)
    in_window[1] && !overcurrent_flag_ff[1] |=> !overcurrent_flag_ff[1])
    else $error("flag one set inside mask window");
  a_flag_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop_mode != stop_d_ff) && !oc_event[0]
    && !(wr_lane0 && awaddr_ff == HSDC_ADDR_FLG && wdata_ff[0])
    |=> $stable(overcurrent_flag_ff[0])) else $error("stop change moved flag");
  a_src_select: assert property (@(posedge aclk) disable iff (!aresetn)
    src_sel_alt[1] && driver_enable_ff[1] && !overcurrent_flag_ff[1]
    |=> drive_out.drv_on[1] == $past(alt_drive[1])) else $error("routed source not used");
  a_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> drive_out.drv_en == $past(driver_enable_ff)) else $error("bias enable lost");
  a_data_view: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == HSDC_ADDR_DATA
    && !driver_enable_ff[0] |=> s_axi_rdata[0] == $past(driver_data_bit_ff[0]))
    else $error("stored data bit not read back");
  a_sync_path: assert property (@(posedge aclk) disable iff (!aresetn)
    !oc_sync2_ff[0] && !overcurrent_flag_ff[0] |=> !overcurrent_flag_ff[0])
    else $error("flag set before detect synchronised");
  // ==========================================================
  // Reset check has no disable so it sees the reset edge itself
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> overcurrent_flag_ff == 2'b00 && !overcurrent_irq_en_ff
    && !driver_module_irq && drive_out == '0) else $error("reset left state behind");
endmodule

// file: common/hsdc_pkg.sv
package hsdc_pkg;
  // ==========================================================
  // Register byte addresses (offsets x4)
  localparam logic [4:0] HSDC_IDX_DATA = 5'h00;
  localparam logic [4:0] HSDC_IDX_CFG  = 5'h01;
  localparam logic [4:0] HSDC_IDX_TEST = 5'h02;
  localparam logic [4:0] HSDC_IDX_IEN  = 5'h06;
  localparam logic [4:0] HSDC_IDX_FLG  = 5'h07;
  localparam logic [7:0] HSDC_ADDR_DATA = {1'b0, HSDC_IDX_DATA, 2'b00};
  localparam logic [7:0] HSDC_ADDR_CFG  = {1'b0, HSDC_IDX_CFG, 2'b00};
  localparam logic [7:0] HSDC_ADDR_TEST = {1'b0, HSDC_IDX_TEST, 2'b00};
  localparam logic [7:0] HSDC_ADDR_IEN  = {1'b0, HSDC_IDX_IEN, 2'b00};
  localparam logic [7:0] HSDC_ADDR_FLG  = {1'b0, HSDC_IDX_FLG, 2'b00};
  // ==========================================================
  // Field positions
  localparam int HSDC_POS_EN   = 0;
  localparam int HSDC_POS_MASK = 4;
  localparam int HSDC_POS_IEN  = 7;
  localparam int HSDC_NDRV     = 2;
  // ==========================================================
  // Reset values
  localparam logic [1:0] HSDC_RST_DRV  = 2'h0;
  localparam logic [7:0] HSDC_RST_TEST = 8'h00;
  // ==========================================================
  // Timing
  localparam int HSDC_CLK_MHZ       = 100;
  localparam int HSDC_MASK_TIME_NS  = 1000;
  localparam int HSDC_MASK_CYCLES   = (HSDC_MASK_TIME_NS * HSDC_CLK_MHZ) / 1000;
  localparam logic [1:0] HSDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HSDC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] drv_on;
    logic [1:0] drv_en;
  } hsdc_drive_t;
endpackage

// file: test/hsdc_drv_model.sv
`timescale 1ns/1ps
// ==========================================================
// Output stage model: a faulty load senses only while switched on
module hsdc_drv_model (
  input  wire logic       aclk,
  input  wire logic [1:0] drv_on,
  input  wire logic [1:0] fault,
  output logic      [1:0] overcurrent_det
);
  initial overcurrent_det = 2'h0;
  // Sense path lags the switch by a cycle, as a real stage would
  always @(posedge aclk) overcurrent_det <= fault & drv_on;
endmodule

// file: test/hsdc_top_tb_top.sv
`timescale 1ns/1ps
module hsdc_top_tb_top;
  import hsdc_pkg::*;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        stop_mode, special_mode, irq, bvalid, rvalid, awready, wready, arready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp, src_sel_alt, alt_drive, det, fault;
  hsdc_drive_t drive_out;
  int          num_errors, check_count, cyc;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Short window keeps the masked run brief
  hsdc_top #(.MASK_CYCLES(12)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_sel_alt(src_sel_alt),
    .alt_drive(alt_drive), .overcurrent_det(det), .stop_mode(stop_mode),
    .special_mode(special_mode), .drive_out(drive_out), .driver_module_irq(irq)
  );

  hsdc_drv_model u_model (
    .aclk(aclk), .drv_on(drive_out.drv_on), .fault(fault), .overcurrent_det(det)
  );

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rd_v, e);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rc("data", HSDC_ADDR_DATA, 32'h0);
    rc("cfg", HSDC_ADDR_CFG, 32'h0);
    rc("test", HSDC_ADDR_TEST, 32'(HSDC_RST_TEST));
    rc("ien", HSDC_ADDR_IEN, 32'h0);
    rc("flg", HSDC_ADDR_FLG, 32'h0);
    chk("rresp", 32'(rsp), 32'(HSDC_RESP_OKAY));
    chk("drive", 32'(drive_out), 32'h0);
    chk("irq", 32'(irq), 32'h0);
  endtask

  task automatic t_cfg();
    wr(HSDC_ADDR_CFG, 32'h30);
    chk("bresp", 32'(rsp), 32'(HSDC_RESP_OKAY));
    rc("cfg", HSDC_ADDR_CFG, 32'h30);
    wr(HSDC_ADDR_CFG, 32'h33);
    rc("cfg", HSDC_ADDR_CFG, 32'h33);
    chk("drv_en", 32'(drive_out.drv_en), 32'h3);
    wr(HSDC_ADDR_CFG, 32'h03);
    rc("cfg", HSDC_ADDR_CFG, 32'h33);
    wr(HSDC_ADDR_CFG, 32'h00);
    rc("cfg", HSDC_ADDR_CFG, 32'h30);
    wr(HSDC_ADDR_CFG, 32'h00);
    rc("cfg", HSDC_ADDR_CFG, 32'h00);
  endtask

  task automatic t_src();
    wr(HSDC_ADDR_CFG, 32'h03);
    repeat (4) @(posedge aclk);
    wr(HSDC_ADDR_DATA, 32'h01);
    repeat (2) @(posedge aclk);
    chk("drv_on", 32'(drive_out.drv_on), 32'h1);
    src_sel_alt <= 2'b10;
    alt_drive <= 2'b10;
    repeat (3) @(posedge aclk);
    chk("drv_on", 32'(drive_out.drv_on), 32'h3);
    rc("data", HSDC_ADDR_DATA, 32'h03);
    wr(HSDC_ADDR_CFG, 32'h00);
    rc("data", HSDC_ADDR_DATA, 32'h01);
    chk("drv_on", 32'(drive_out.drv_on), 32'h0);
    src_sel_alt <= 2'b00;
  endtask

  task automatic t_oc();
    wr(HSDC_ADDR_CFG, 32'h03);
    repeat (4) @(posedge aclk);
    wr(HSDC_ADDR_DATA, 32'h03);
    wr(HSDC_ADDR_IEN, 32'h80);
    fault <= 2'b01;
    repeat (8) @(posedge aclk);
    fault <= 2'b00;
    chk("drv_on", 32'(drive_out.drv_on), 32'h2);
    chk("irq", 32'(irq), 32'h1);
    rc("flg", HSDC_ADDR_FLG, 32'h01);
    wr(HSDC_ADDR_FLG, 32'h00);
    rc("flg", HSDC_ADDR_FLG, 32'h01);
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    rc("flg", HSDC_ADDR_FLG, 32'h01);
    rc("data", HSDC_ADDR_DATA, 32'h00);
    stop_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(HSDC_ADDR_DATA, 32'h03);
    wr(HSDC_ADDR_FLG, 32'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    chk("drv_on", 32'(drive_out.drv_on), 32'h3);
    wr(HSDC_ADDR_IEN, 32'h00);
    fault <= 2'b10;
    repeat (8) @(posedge aclk);
    fault <= 2'b00;
    chk("irq", 32'(irq), 32'h0);
    rc("flg", HSDC_ADDR_FLG, 32'h02);
    wr(HSDC_ADDR_IEN, 32'h80);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(HSDC_ADDR_FLG, 32'h03);
    rc("flg", HSDC_ADDR_FLG, 32'h00);
    chk("irq", 32'(irq), 32'h0);
  endtask

  task automatic t_mask();
    wr(HSDC_ADDR_DATA, 32'h00);
    wr(HSDC_ADDR_CFG, 32'h00);
    wr(HSDC_ADDR_CFG, 32'h10);
    wr(HSDC_ADDR_CFG, 32'h11);
    repeat (4) @(posedge aclk);
    fault <= 2'b01;
    wr(HSDC_ADDR_DATA, 32'h01);
    repeat (6) @(posedge aclk);
    chk("masked", 32'(drive_out.drv_on), 32'h1);
    repeat (20) @(posedge aclk);
    chk("late", 32'(drive_out.drv_on), 32'h0);
    fault <= 2'b00;
    rc("flg", HSDC_ADDR_FLG, 32'h01);
    wr(HSDC_ADDR_FLG, 32'h01);
  endtask

  task automatic t_test();
    wr(HSDC_ADDR_TEST, 32'ha5);
    rc("test", HSDC_ADDR_TEST, 32'h00);
    special_mode <= 1'b1;
    wr(HSDC_ADDR_TEST, 32'ha5);
    rc("test", HSDC_ADDR_TEST, 32'ha5);
    special_mode <= 1'b0;
    wr(8'h40, 32'hff);
    chk("bresp", 32'(rsp), 32'(HSDC_RESP_SLVERR));
    rc("unmapped", 8'h40, 32'h0);
    chk("rresp", 32'(rsp), 32'(HSDC_RESP_SLVERR));
  endtask

  // Mid-run reset with a flag and the irq enable set
  task automatic t_rerun();
    fault <= 2'b01;
    repeat (8) @(posedge aclk);
    rc("flg", HSDC_ADDR_FLG, 32'h01);
    aresetn <= 1'b0;
    fault <= 2'b00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
  endtask

  // ==========================================================
  // Main sequence and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode, special_mode} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {src_sel_alt, alt_drive, fault} = 6'h00;
    wstrb = 4'hf;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_src();
    t_oc();
    t_mask();
    t_test();
    t_rerun();
    results();
  end
endmodule
